// [rtl/disk_port_ready.sv]
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module disk_port_ready #(
  parameter int WORD_W = 16,
  parameter int REVS = disk_port_pkg::TIMEOUT_REVS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // io processor port
  input wire logic read_port_strobe,
  input wire logic write_port_strobe,
  input wire logic exp_sel,
  input wire logic [WORD_W-1:0] iop_wdata,
  output logic [WORD_W-1:0] iop_rdata,
  output logic ready,
  output logic port_access_active,
  // transfer circuitry
  input wire logic rw_window,
  input wire logic word_start_pulse,
  input wire logic index_pulse,
  input wire logic sector_pulse,
  output logic transfer_window_on,
  output logic timeout,
  output logic write_gate,
  output logic id_field_write,
  output logic data_field_write,
  output logic addr_mark_write,
  // expansion bus
  input wire logic expansion_wait_first_n,
  input wire logic expansion_wait_second_n,
  input wire logic [15:0] exp_data_in,
  output logic [15:0] exp_data_out,
  output logic exp_data_oe,
  // drive control cable
  output logic [3:0] device_select,
  output logic [3:0] head_select,
  output logic [3:0] command_out,
  input wire logic [7:0] gp_in,
  output logic [7:0] gp_out,
  output logic gp_oe,
  input wire logic [7:0] status_in,
  // read/write cable
  input wire logic [1:0] read_data_in,
  input wire logic [1:0] rw_clock_in,
  output logic [1:0] write_data_out,
  input wire logic [1:0] rw_status_in
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [4:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] sect_len;
    logic ready_latch;
    logic window;
    logic timeout;
    logic [1:0] revs;
    logic [WORD_W-1:0] shifter;
    logic [WORD_W-1:0] write_buf;
    logic [WORD_W-1:0] read_buf;
    logic [WORD_W-1:0] iop_rdata;
    logic wr_bit;
    disk_port_pkg::fmt_e fmt;
    logic [15:0] word_cnt;
    logic [7:0] sect_num;
    logic am;
    logic [15:0] exp_out;
    logic exp_oe;
  } state_s;

  state_s st_q, st_d;
  logic exp_ok, xfer, bit_tick, rd_bit, drv, searching, sync_hit, sect_start;
  logic wr_fire, fmt_field, writing;
  logic [31:0] status_word;
  localparam int CTRL_DRV_HI = disk_port_pkg::CTRL_DRV + 1;

  assign port_access_active = read_port_strobe | write_port_strobe;
  assign exp_ok = expansion_wait_first_n & expansion_wait_second_n;
  // timeout overrides every wait so a failed search never hangs the processor
  assign ready = st_q.timeout | (exp_ok & (~port_access_active | st_q.ready_latch));
  assign xfer = port_access_active & ready;
  assign drv = st_q.ctrl[disk_port_pkg::CTRL_DRV];
  assign bit_tick = rw_clock_in[drv];
  assign rd_bit = read_data_in[drv];
  assign fmt_field = st_q.fmt == disk_port_pkg::FMT_ID || st_q.fmt == disk_port_pkg::FMT_ODD ||
                     st_q.fmt == disk_port_pkg::FMT_EVEN;
  assign writing = fmt_field | st_q.ctrl[disk_port_pkg::CTRL_WRITE];
  assign searching = rw_window & ~st_q.window & ~fmt_field;
  assign sync_hit = searching & (st_q.shifter[7:0] == disk_port_pkg::SYNC_BYTE);
  assign sect_start = st_q.ctrl[disk_port_pkg::CTRL_HARD] ? sector_pulse :
                      (word_start_pulse & (st_q.word_cnt == st_q.sect_len - 16'h0001));
  assign wr_fire = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
  assign status_word = {7'h00, st_q.fmt, 2'h0, rw_status_in, status_in, 4'h0,
                        st_q.ready_latch, st_q.timeout, st_q.window, ready};

  always_comb begin
    st_d = st_q;
    // bus handshakes
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
    end
    st_d.ctrl[disk_port_pkg::CTRL_FMT_GO] = 1'b0;
    if (wr_fire) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = disk_port_pkg::RESP_OKAY;
      case (st_q.waddr)
        disk_port_pkg::CTRL_OFF: begin
          for (int b = 0; b < 4; b++) begin
            if (st_q.wstrb[b]) begin
              st_d.ctrl[b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
          end
        end
        disk_port_pkg::IRQ_STAT_OFF: begin
          if (st_q.wstrb[0]) begin
            st_d.irq_stat = st_q.irq_stat & ~st_q.wdata[2:0];
          end
        end
        disk_port_pkg::IRQ_MASK_OFF: begin
          if (st_q.wstrb[0]) begin
            st_d.irq_mask = st_q.wdata[2:0];
          end
        end
        disk_port_pkg::SECT_LEN_OFF: begin
          for (int b = 0; b < 2; b++) begin
            if (st_q.wstrb[b]) begin
              st_d.sect_len[b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
          end
        end
        disk_port_pkg::STAT_OFF: begin
        end
        default: st_d.bresp = disk_port_pkg::RESP_SLVERR;
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = disk_port_pkg::RESP_OKAY;
      case (s_axi_araddr)
        disk_port_pkg::CTRL_OFF: st_d.rdata = st_q.ctrl;
        disk_port_pkg::STAT_OFF: st_d.rdata = status_word;
        disk_port_pkg::IRQ_STAT_OFF: st_d.rdata = {29'h0, st_q.irq_stat};
        disk_port_pkg::IRQ_MASK_OFF: st_d.rdata = {29'h0, st_q.irq_mask};
        disk_port_pkg::SECT_LEN_OFF: st_d.rdata = {16'h0, st_q.sect_len};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = disk_port_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ready latch: clear on a port access while set, set on word start wins
    if (port_access_active && st_q.ready_latch) begin
      st_d.ready_latch = 1'b0;
    end
    if (word_start_pulse && st_q.window && rw_window) begin
      st_d.ready_latch = 1'b1;
    end

    // word shifter, serial side
    if (bit_tick) begin
      st_d.shifter = {st_q.shifter[WORD_W-2:0], writing ? 1'b0 : rd_bit};
      st_d.wr_bit = writing & st_q.shifter[WORD_W-1];
    end
    if (word_start_pulse && st_q.window) begin
      if (writing) begin
        st_d.shifter = st_q.write_buf;
      end else begin
        st_d.read_buf = st_q.shifter;
      end
    end

    // parallel side, buffers or expansion bus
    if (xfer && write_port_strobe) begin
      if (exp_sel) begin
        st_d.exp_out = st_q.ctrl[disk_port_pkg::CTRL_EXP_WIDE] ? 16'(iop_wdata) :
                       {8'h00, iop_wdata[7:0]};
      end else begin
        st_d.write_buf = iop_wdata;
      end
    end
    if (xfer && read_port_strobe) begin
      if (exp_sel) begin
        st_d.iop_rdata = WORD_W'(st_q.ctrl[disk_port_pkg::CTRL_EXP_WIDE] ? exp_data_in :
                                 {8'h00, exp_data_in[7:0]});
      end else begin
        st_d.iop_rdata = st_q.read_buf;
      end
    end
    st_d.exp_oe = exp_sel & write_port_strobe;

    // sector search and its revolution timeout
    if (sync_hit) begin
      st_d.window = 1'b1;
    end
    if (searching && index_pulse && !st_q.timeout) begin
      st_d.revs = st_q.revs + 2'h1;
      if (st_q.revs == 2'(REVS - 1)) begin
        st_d.timeout = 1'b1;
      end
    end
    if (!rw_window) begin
      st_d.window = 1'b0;
      st_d.timeout = 1'b0;
      st_d.revs = 2'h0;
    end

    // track format, one track per command
    st_d.am = 1'b0;
    if (word_start_pulse) begin
      st_d.word_cnt = st_q.word_cnt + 16'h0001;
    end
    if (sect_start) begin
      st_d.word_cnt = 16'h0000;
      st_d.sect_num = st_q.sect_num + 8'h01;
    end
    if (index_pulse) begin
      st_d.word_cnt = 16'h0000;
      st_d.sect_num = 8'h00;
    end
    case (st_q.fmt)
      disk_port_pkg::FMT_IDLE: begin
        if (st_d.ctrl[disk_port_pkg::CTRL_FMT_GO]) begin
          st_d.fmt = disk_port_pkg::FMT_WAIT;
        end
      end
      disk_port_pkg::FMT_WAIT: begin
        if (index_pulse) begin
          st_d.fmt = disk_port_pkg::FMT_ID;
          st_d.am = ~st_q.ctrl[disk_port_pkg::CTRL_HARD];
        end
      end
      disk_port_pkg::FMT_ID: begin
        st_d.am = sect_start & ~st_q.ctrl[disk_port_pkg::CTRL_HARD];
        if (index_pulse) begin
          st_d.fmt = disk_port_pkg::FMT_ODD;
        end
      end
      disk_port_pkg::FMT_ODD: begin
        if (index_pulse) begin
          st_d.fmt = disk_port_pkg::FMT_EVEN;
        end
      end
      disk_port_pkg::FMT_EVEN: begin
        if (index_pulse) begin
          st_d.fmt = disk_port_pkg::FMT_IDLE;
        end
      end
      default: st_d.fmt = disk_port_pkg::FMT_IDLE;
    endcase
    if (fmt_field && rw_window) begin
      st_d.window = 1'b1;
    end

    // sticky events; a set in the clearing cycle survives
    if (searching && index_pulse && st_q.revs == 2'(REVS - 1)) begin
      st_d.irq_stat[disk_port_pkg::IRQ_TIMEOUT] = 1'b1;
    end
    if (sync_hit) begin
      st_d.irq_stat[disk_port_pkg::IRQ_SYNC] = 1'b1;
    end
    if (st_q.fmt == disk_port_pkg::FMT_EVEN && index_pulse) begin
      st_d.irq_stat[disk_port_pkg::IRQ_FMT_DONE] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.ctrl <= disk_port_pkg::CTRL_RST;
      st_q.sect_len <= disk_port_pkg::SECT_LEN_RST;
      st_q.fmt <= disk_port_pkg::FMT_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = ~st_q.aw_got;
  assign s_axi_wready = ~st_q.w_got;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign irq = |(st_q.irq_stat & st_q.irq_mask);
  assign iop_rdata = st_q.iop_rdata;
  assign transfer_window_on = st_q.window;
  assign timeout = st_q.timeout;
  assign write_gate = writing & st_q.window;
  assign id_field_write = st_q.fmt == disk_port_pkg::FMT_ID;
  assign data_field_write = (st_q.fmt == disk_port_pkg::FMT_ODD && st_q.sect_num[0]) ||
                            (st_q.fmt == disk_port_pkg::FMT_EVEN && !st_q.sect_num[0]);
  assign addr_mark_write = st_q.am;
  assign exp_data_out = st_q.exp_out;
  assign exp_data_oe = st_q.exp_oe;
  // control cable groups; up to four chained drives
  assign device_select = 4'h1 << st_q.ctrl[CTRL_DRV_HI:disk_port_pkg::CTRL_DRV];
  assign head_select = st_q.ctrl[disk_port_pkg::CTRL_HEAD +: 4];
  assign command_out = st_q.ctrl[disk_port_pkg::CTRL_CMD +: 4];
  assign gp_out = st_q.ctrl[disk_port_pkg::CTRL_GP +: 8];
  assign gp_oe = st_q.ctrl[disk_port_pkg::CTRL_GP_OE];
  // write data to physical address 0 or 1 only
  assign write_data_out = drv ? {st_q.wr_bit, 1'b0} : {1'b0, st_q.wr_bit};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence word_started;
    word_start_pulse && st_q.window && rw_window;
  endsequence
  sequence fmt_rev(disk_port_pkg::fmt_e s);
    st_q.fmt == s && index_pulse;
  endsequence

  ready_idle_a: assert property (!port_access_active && exp_ok |-> ready)
    else $error("ready low without access");
  access_wait_a: assert property (port_access_active && !st_q.ready_latch && !st_q.timeout |-> !ready)
    else $error("access did not drop ready");
  latch_set_a: assert property (word_started |=> st_q.ready_latch && (ready || !exp_ok))
    else $error("word start did not set ready");
  latch_clear_a: assert property (xfer && st_q.ready_latch && !word_start_pulse |=> !st_q.ready_latch)
    else $error("ready latch not cleared after word");
  window_fall_a: assert property (!rw_window |=> !st_q.window && !st_q.timeout)
    else $error("window stayed open");
  timeout_ready_a: assert property (st_q.timeout |-> ready) else $error("timeout did not release");
  exp_wait_a: assert property (!exp_ok && !st_q.timeout |-> !ready) else $error("expansion wait ignored");
  sync_found_a: assert property (sync_hit && rw_window |=> st_q.window) else $error("sync byte missed");
  fmt_order_a: assert property (fmt_rev(disk_port_pkg::FMT_ID) |=>
    st_q.fmt == disk_port_pkg::FMT_ODD && !data_field_write) else $error("format order wrong");
  fmt_end_a: assert property (fmt_rev(disk_port_pkg::FMT_EVEN) |=> st_q.fmt == disk_port_pkg::FMT_IDLE)
    else $error("format not one track");
endmodule
`default_nettype wire

// [rtl/disk_port_pkg.sv]
package disk_port_pkg;
  localparam logic [4:0] CTRL_OFF = 5'h00;
  localparam logic [4:0] STAT_OFF = 5'h04;
  localparam logic [4:0] IRQ_STAT_OFF = 5'h08;
  localparam logic [4:0] IRQ_MASK_OFF = 5'h0c;
  localparam logic [4:0] SECT_LEN_OFF = 5'h10;
  localparam int CTRL_HARD = 0;
  localparam int CTRL_FMT_GO = 1;
  localparam int CTRL_EXP_WIDE = 2;
  localparam int CTRL_WRITE = 3;
  localparam int CTRL_DRV = 4;
  localparam int CTRL_HEAD = 8;
  localparam int CTRL_CMD = 12;
  localparam int CTRL_GP = 16;
  localparam int CTRL_GP_OE = 24;
  localparam int STAT_CABLE = 8;
  localparam int STAT_RW = 16;
  localparam int STAT_FMT = 20;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_SYNC = 1;
  localparam int IRQ_FMT_DONE = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] SYNC_BYTE = 8'h19;
  localparam int TIMEOUT_REVS = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SECT_LEN_RST = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    FMT_IDLE = 5'b00001,
    FMT_WAIT = 5'b00010,
    FMT_ID = 5'b00100,
    FMT_ODD = 5'b01000,
    FMT_EVEN = 5'b10000
  } fmt_e;
endpackage

// [dv/disk_xfer_model.sv]
`timescale 1ns/10ps
`default_nettype none
module disk_xfer_model (
  // clock
  input wire logic aclk,
  // toward the block
  output logic word_start_pulse,
  output logic index_pulse,
  output logic sector_pulse,
  output logic [1:0] read_data_in,
  output logic [1:0] rw_clock_in
);
  initial begin
    word_start_pulse = 1'b0;
    index_pulse = 1'b0;
    sector_pulse = 1'b0;
    read_data_in = 2'h0;
    rw_clock_in = 2'h0;
  end
  // bit 15 of each word leaves the shifter first
  task automatic word_start();
    @(posedge aclk);
    word_start_pulse <= 1'b1;
    @(posedge aclk);
    word_start_pulse <= 1'b0;
  endtask
  // one mark per disk revolution
  task automatic index();
    @(posedge aclk);
    index_pulse <= 1'b1;
    @(posedge aclk);
    index_pulse <= 1'b0;
  endtask
  // 1998h holds the sync byte whichever way the shifter fills
  task automatic send_sync();
    logic [15:0] pat;
    pat = 16'h1998;
    for (int i = 15; i >= 0; i--) begin
      @(posedge aclk);
      read_data_in <= {1'b0, pat[i]};
      rw_clock_in <= 2'b01;
    end
    @(posedge aclk);
    rw_clock_in <= 2'b00;
    read_data_in <= 2'b01;
  endtask
endmodule
`default_nettype wire

// [dv/disk_port_ready_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module disk_port_ready_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic irq, ready, port_access_active, transfer_window_on, timeout;
  logic read_port_strobe = 1'b0, write_port_strobe = 1'b0, rw_window = 1'b0;
  logic [15:0] iop_wdata = 16'h0, exp_data_in = 16'h0;
  logic word_start_pulse, index_pulse, sector_pulse;
  logic [1:0] read_data_in, rw_clock_in;
  logic wait0_n = 1'b1, wait1_n = 1'b1;
  logic [7:0] gp_in = 8'h0, status_in = 8'h0;
  logic [1:0] rw_status_in = 2'h0;
  logic exp_sel = 1'b0;
  logic [15:0] iop_rdata, exp_data_out;
  logic [3:0] device_select, head_select, command_out;
  logic [7:0] gp_out;
  logic [1:0] write_data_out;
  logic exp_data_oe, gp_oe, write_gate, id_field_write, data_field_write, addr_mark_write;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  event obs_ev, dat_ev, cab_ev;

  always #50 aclk = ~aclk;

  disk_port_ready i_disk_port_ready (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq),
    .read_port_strobe(read_port_strobe), .write_port_strobe(write_port_strobe), .exp_sel(exp_sel),
    .iop_wdata(iop_wdata), .iop_rdata(iop_rdata), .ready(ready), .port_access_active(port_access_active),
    .rw_window(rw_window), .word_start_pulse(word_start_pulse), .index_pulse(index_pulse),
    .sector_pulse(sector_pulse), .transfer_window_on(transfer_window_on), .timeout(timeout),
    .write_gate(write_gate), .id_field_write(id_field_write), .data_field_write(data_field_write),
    .addr_mark_write(addr_mark_write),
    .expansion_wait_first_n(wait0_n), .expansion_wait_second_n(wait1_n),
    .exp_data_in(exp_data_in), .exp_data_out(exp_data_out), .exp_data_oe(exp_data_oe),
    .device_select(device_select), .head_select(head_select), .command_out(command_out), .gp_in(gp_in),
    .gp_out(gp_out), .gp_oe(gp_oe),
    .status_in(status_in), .read_data_in(read_data_in), .rw_clock_in(rw_clock_in),
    .write_data_out(write_data_out), .rw_status_in(rw_status_in)
  );

  disk_xfer_model i_disk_xfer_model (
    .aclk(aclk), .word_start_pulse(word_start_pulse), .index_pulse(index_pulse),
    .sector_pulse(sector_pulse), .read_data_in(read_data_in), .rw_clock_in(rw_clock_in)
  );

  task automatic cmp(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    total_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // results appear as a read answer, a write response or a sampled port snapshot
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      cmp(s_axi_rdata);
      cmp({30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid && s_axi_bready) begin
      cmp({30'h0, s_axi_bresp});
    end
  end
  always @(obs_ev) cmp({27'h0, ready, port_access_active, transfer_window_on, timeout, irq});
  always @(dat_ev) cmp({exp_data_out, iop_rdata});
  always @(cab_ev) cmp({4'h0, exp_data_oe, device_select, head_select, command_out, gp_out, gp_oe, write_data_out,
                        write_gate, id_field_write, data_field_write, addr_mark_write});

  // snapshots are taken mid-cycle; stimulus resumes just after the next rising edge
  task automatic chk(input logic [4:0] e);
    @(negedge aclk);
    exp_q.push_back({27'h0, e});
    ->obs_ev;
    @(posedge aclk);
  endtask

  task automatic note(input logic [31:0] e, input logic cab);
    @(negedge aclk);
    exp_q.push_back(e);
    if (cab) ->cab_ev;
    else ->dat_ev;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = disk_port_pkg::RESP_OKAY);
    bit aw_done, w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    n = 0;
    exp_q.push_back({30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done) && n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back(d);
    exp_q.push_back({30'h0, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic rd_sel;
    logic [4:0] f;
    logic [31:0] st;
    logic [31:0] c;
    void'($urandom(32'h4587));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    status_in <= 8'($urandom);
    rw_status_in <= 2'($urandom);
    gp_in <= 8'($urandom);
    exp_data_in <= 16'($urandom);
    @(posedge aclk);
    chk(5'b10000);
    rd(disk_port_pkg::CTRL_OFF, disk_port_pkg::CTRL_RST, disk_port_pkg::RESP_OKAY);
    rd(disk_port_pkg::SECT_LEN_OFF, {16'h0, disk_port_pkg::SECT_LEN_RST}, disk_port_pkg::RESP_OKAY);
    rd(5'h14, 32'h0, disk_port_pkg::RESP_SLVERR);
    wr(5'h14, 32'h0, disk_port_pkg::RESP_SLVERR);
    wr(disk_port_pkg::IRQ_MASK_OFF, 32'h7);
    // the processor holds its port access while it waits
    rd_sel = 1'($urandom);
    read_port_strobe <= rd_sel;
    write_port_strobe <= !rd_sel;
    iop_wdata <= 16'($urandom);
    chk(5'b01000);
    rw_window <= 1'b1;
    i_disk_xfer_model.send_sync();
    repeat (2) @(posedge aclk);
    chk(5'b01101);
    for (int w = 0; w < 3; w++) begin
      i_disk_xfer_model.word_start();
      chk(5'b11101);
      chk(5'b01101);
      note({16'h0, rd_sel ? 16'h1998 : 16'h0}, 1'b0);
      iop_wdata <= 16'($urandom);
      repeat (4) @(posedge aclk);
    end
    rw_window <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(5'b01001);
    wr(disk_port_pkg::IRQ_STAT_OFF, 32'h7);
    chk(5'b01000);
    // search with no sync byte: released after two revolutions
    rw_window <= 1'b1;
    i_disk_xfer_model.index();
    chk(5'b01000);
    i_disk_xfer_model.index();
    repeat (2) @(posedge aclk);
    chk(5'b11011);
    wait0_n <= 1'b0;
    chk(5'b11011);
    // byte-wide expansion transfers while the timeout holds ready
    exp_sel <= 1'b1;
    read_port_strobe <= 1'b0;
    write_port_strobe <= 1'b1;
    wait0_n <= 1'b1;
    @(posedge aclk);
    read_port_strobe <= 1'b1;
    write_port_strobe <= 1'b0;
    note({4'h0, 1'b1, 4'h1, 23'h0}, 1'b1);
    note({8'h00, iop_wdata[7:0], 8'h00, exp_data_in[7:0]}, 1'b0);
    exp_sel <= 1'b0;
    read_port_strobe <= 1'b0;
    write_port_strobe <= 1'b0;
    wait0_n <= 1'b1;
    rw_window <= 1'b0;
    repeat (2) @(posedge aclk);
    wr(disk_port_pkg::IRQ_STAT_OFF, 32'h7);
    chk(5'b10000);
    for (int i = 0; i < 2; i++) begin
      wait0_n <= (i != 0);
      wait1_n <= (i == 0);
      chk(5'b00000);
      wait0_n <= 1'b1;
      wait1_n <= 1'b1;
      chk(5'b10000);
    end
    // one command, one track, revolution by revolution, soft then hard
    for (int h = 0; h < 2; h++) begin
      wr(disk_port_pkg::CTRL_OFF, (32'h1 << disk_port_pkg::CTRL_FMT_GO) | h);
      for (int k = 0; k < 5; k++) begin
        if (k > 0) i_disk_xfer_model.index();
        f = (k < 4) ? (5'b00010 << k) : 5'b00001;
        st = (32'(f) << disk_port_pkg::STAT_FMT) | (32'(rw_status_in) << disk_port_pkg::STAT_RW);
        st = st | (32'(status_in) << disk_port_pkg::STAT_CABLE) | 32'h1;
        rd(disk_port_pkg::STAT_OFF, st, disk_port_pkg::RESP_OKAY);
      end
      rd(disk_port_pkg::IRQ_STAT_OFF, 32'h4, disk_port_pkg::RESP_OKAY);
      chk(5'b10001);
      wr(disk_port_pkg::IRQ_STAT_OFF, 32'h7);
      chk(5'b10000);
    end
    // control cable fields from a random control word, format and mode bits kept clear
    c = $urandom & 32'h01ff_fff0;
    wr(disk_port_pkg::CTRL_OFF, c);
    note({4'h0, 1'b0, 4'h1 << c[5:4], c[11:8], c[15:12], c[23:16], c[24], 2'b00, 4'h0}, 1'b1);
    repeat (5) @(posedge aclk);
    print_verdict();
  end
endmodule
`default_nettype wire
